// File: rtl/ppl_pkg.sv
// Shared types, field layouts and timing constants of the parallel load port
package ppl_pkg;

	// Reference clock of the control logic
	localparam longint unsigned SYS_CLK_HZ = 50_000_000;

	// Printed times
	localparam longint unsigned T_CF2ST0_NS        = 600;
	localparam longint unsigned T_CFG_MIN_US       = 2;
	localparam longint unsigned T_STATUS_MIN_US    = 268;
	localparam longint unsigned T_STATUS_MAX_US    = 1506;
	localparam longint unsigned T_CD2UM_MIN_US     = 175;
	localparam longint unsigned T_CD2UM_MAX_US     = 437;
	localparam longint unsigned T_CLK_MAX_PERIOD_NS = 10;
	localparam longint unsigned CD2CU_PERIODS      = 4;
	localparam longint unsigned UCLK_INIT_PERIODS  = 8576;
	// Power-on delay; plain default, not a printed figure
	localparam longint unsigned T_POR_US           = 100;

	// Least time, rounded up, never below one cycle
	function automatic longint unsigned cyc_up(
		input longint unsigned t_ns, input longint unsigned hz);
		longint unsigned c;
		c = (t_ns * hz + 64'd999_999_999) / 64'd1_000_000_000;
		return (c == 0) ? 1 : c;
	endfunction : cyc_up

	// Longest time, rounded down, never below one cycle
	function automatic longint unsigned cyc_dn(
		input longint unsigned t_ns, input longint unsigned hz);
		longint unsigned c;
		c = (t_ns * hz) / 64'd1_000_000_000;
		return (c == 0) ? 1 : c;
	endfunction : cyc_dn

	localparam longint unsigned CF2ST0_CYC =
		cyc_dn(T_CF2ST0_NS, SYS_CLK_HZ);
	localparam longint unsigned STATUS_MIN_CYC =
		cyc_up(T_STATUS_MIN_US * 1000, SYS_CLK_HZ);
	localparam longint unsigned STATUS_MAX_CYC =
		cyc_dn(T_STATUS_MAX_US * 1000, SYS_CLK_HZ);
	localparam longint unsigned CD2UM_MIN_CYC =
		cyc_up(T_CD2UM_MIN_US * 1000, SYS_CLK_HZ);
	localparam longint unsigned CD2UM_MAX_CYC =
		cyc_dn(T_CD2UM_MAX_US * 1000, SYS_CLK_HZ);
	localparam longint unsigned CD2CU_CYC =
		cyc_up(CD2CU_PERIODS * T_CLK_MAX_PERIOD_NS, SYS_CLK_HZ);
	localparam longint unsigned POR_CYC =
		cyc_up(T_POR_US * 1000, SYS_CLK_HZ);

	// Reset values
	localparam logic [31:0] WORD_RST  = 32'h0000_0000;
	localparam logic [3:0]  RATIO_RST = 4'h1;

	// Falling link edges that close a load
	localparam logic [1:0]  END_FALLS = 2'h2;

	typedef enum logic [1:0] {
		WIDTH_8,
		WIDTH_16,
		WIDTH_32
	} width_e;

	typedef struct packed {
		width_e width;
		logic   decompress;
		logic   secure;
	} cfg_mode_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} cfg_word_s;

	// Configuration clocks per data word
	function automatic logic [3:0] word_ratio(input cfg_mode_s m);
		logic [3:0] r;
		r = 4'h1;
		case (m.width)
			WIDTH_8:  r = m.decompress ? 4'h2 : 4'h1;
			WIDTH_16: r = m.decompress ? 4'h4 : (m.secure ? 4'h2 : 4'h1);
			WIDTH_32: r = m.decompress ? 4'h8 : (m.secure ? 4'h4 : 4'h1);
			default:  r = 4'h1;
		endcase
		return r;
	endfunction : word_ratio

	// Active data lanes for a width
	function automatic logic [31:0] lane_mask(input width_e w);
		logic [31:0] k;
		k = 32'hffff_ffff;
		case (w)
			WIDTH_8:  k = 32'h0000_00ff;
			WIDTH_16: k = 32'h0000_ffff;
			default:  k = 32'hffff_ffff;
		endcase
		return k;
	endfunction : lane_mask

endpackage : ppl_pkg

// File: rtl/ppl_link.sv
// Link-side capture running on the host's configuration clock
`timescale 1ns/10ps
module ppl_link (
	// Link clock and reset
	input  wire logic          i_config_clock,
	input  wire logic          i_rst_b,
	// Levels from the control domain, static while armed
	input  wire logic          i_arm,
	input  wire logic [3:0]    i_ratio,
	input  wire ppl_pkg::width_e i_width,
	// Data pins
	input  wire logic [31:0]   i_data,
	// Captured word and event toggles
	output logic [31:0]        o_word,
	output logic               o_word_tgl,
	output logic               o_fall_tgl
);
	import ppl_pkg::*;

	logic        cap_rst_b;
	logic [3:0]  phase_reg, phase_next;
	logic [31:0] word_reg, word_next;
	logic        tgl_reg, tgl_next;
	logic        fall_reg, fall_next;

	// Disarm holds capture in reset. The host clock may stand still up to
	// the first word, so a synchroniser here would swallow that word; arm
	// settles long before the first rising edge instead.
	assign cap_rst_b = i_rst_b & i_arm;

	// Rising-edge capture: one word per ratio period
	always_comb begin
		phase_next = phase_reg;
		word_next  = word_reg;
		tgl_next   = tgl_reg;
		if (phase_reg == 4'h0) begin
			word_next = i_data & lane_mask(i_width);
			tgl_next  = ~tgl_reg;
		end
		// Remaining cycles of the period serve decrypt and decompress
		if (phase_reg >= i_ratio - 4'h1) begin
			phase_next = 4'h0;
		end else begin
			phase_next = phase_reg + 4'h1;
		end
	end

	// Rising edges after disarm are ignored
	always_ff @(posedge i_config_clock or negedge cap_rst_b) begin
		if (!cap_rst_b) begin
			phase_reg <= 4'h0;
			word_reg  <= WORD_RST;
			tgl_reg   <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			word_reg  <= word_next;
			tgl_reg   <= tgl_next;
		end
	end

	// Every falling edge flips a toggle for the control domain
	always_comb begin
		fall_next = ~fall_reg;
	end

	always_ff @(negedge i_config_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fall_reg <= 1'b0;
		end else begin
			fall_reg <= fall_next;
		end
	end

	assign o_word     = word_reg;
	assign o_word_tgl = tgl_reg;
	assign o_fall_tgl = fall_reg;

endmodule : ppl_link

// File: rtl/passive_parallel_load.sv
// Passive parallel configuration load port, device side
// Operation
// - 8-bit width: one clock per word, two with decompression.
// - 16-bit: one clock; two with security only; four with decompression.
// - 32-bit: one clock; four with security only; eight with decompression.
// - Device latches one word per ratio period, rest used for processing.
// - User mode has request, status, done high; request low restarts.
// - After power-up status stays low for the power-on delay.
// - Load-complete stays low from power-up until configuration finishes.
// - Load-complete rises only after the whole image is received.
// - Enabled init-done output stays low until initialization finishes.
// - Configuration clock is ignored once configuration completes.
// - 16-bit uses data 15..0, 8-bit uses 7..0; pins return to user.
// - Request falling drives load-complete and status low within 600 ns.
// - Status low pulse lasts 268 to 1506 us unless held externally.
// - Status released within 1506 us of request rising.
// - Internal init enters user mode 175 to 437 us after done.
// - User clock enabled four max clock periods after done, then 8576.
`timescale 1ns/10ps
module passive_parallel_load #(
	parameter int unsigned POR_CYCLES      = 32'(ppl_pkg::POR_CYC),
	parameter int unsigned STATUS_CYCLES   = 32'(ppl_pkg::STATUS_MIN_CYC),
	parameter int unsigned INIT_CYCLES     = 32'(ppl_pkg::CD2UM_MIN_CYC),
	parameter int unsigned UCLK_PERIODS    = 32'(ppl_pkg::UCLK_INIT_PERIODS)
) (
	// System clock and reset
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst_b,
	// Link from the host
	input  wire logic                i_config_clock,
	input  wire logic [31:0]         i_data,
	input  wire logic                i_reconfig_req_b,
	// Open-drain status line
	input  wire logic                i_status_b_in,
	output logic                     o_status_b_out,
	output logic                     o_status_b_oe,
	// Open-drain load-complete line
	input  wire logic                i_load_done_in,
	output logic                     o_load_done_out,
	output logic                     o_load_done_oe,
	// Open-drain init-done line
	output logic                     o_init_done_out,
	output logic                     o_init_done_oe,
	// Initialization clock and init-done options
	input  wire logic                i_user_init_clock,
	input  wire logic                i_user_clock_opt,
	input  wire logic                i_init_done_opt,
	// Mode and image length
	input  wire ppl_pkg::cfg_mode_s  i_mode,
	input  wire logic [31:0]         i_image_words,
	// Captured words and state
	output ppl_pkg::cfg_word_s       o_word,
	output logic                     o_user_mode
);
	import ppl_pkg::*;

	typedef enum logic [2:0] {
		ST_POR,
		ST_RESET,
		ST_STATUS,
		ST_LOAD,
		ST_EDGES,
		ST_INIT,
		ST_USER
	} state_e;

	// Pin and link toggle synchronisers
	logic [1:0] req_sync_reg;
	logic [1:0] st_sync_reg;
	logic [2:0] uclk_sync_reg;
	logic [2:0] tgl_sync_reg;
	logic [2:0] edg_sync_reg;
	logic [1:0] ld_sync_reg;

	state_e      state_reg, state_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [31:0] words_reg, words_next;
	logic [31:0] ucnt_reg, ucnt_next;
	logic        st_oe_reg, st_oe_next;
	logic        ld_oe_reg, ld_oe_next;
	logic        id_oe_reg, id_oe_next;
	logic        arm_reg, arm_next;
	logic [1:0]  falls_reg, falls_next;
	logic        user_reg, user_next;
	cfg_mode_s   mode_reg, mode_next;
	cfg_word_s   word_reg, word_next;

	logic [31:0] link_word;
	logic        link_tgl;
	logic        link_fall;
	logic        req_b;
	logic        status_hi;
	logic        word_evt;
	logic        uclk_rise;
	logic        fall_evt;
	logic        ld_high;

	ppl_link u_link (
		.i_config_clock (i_config_clock),
		.i_rst_b        (i_rst_b),
		.i_arm          (arm_reg),
		.i_ratio        (word_ratio(mode_reg)),
		.i_width        (mode_reg.width),
		.i_data         (i_data),
		.o_word         (link_word),
		.o_word_tgl     (link_tgl),
		.o_fall_tgl     (link_fall)
	);

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			req_sync_reg  <= 2'h0;
			st_sync_reg   <= 2'h0;
			uclk_sync_reg <= 3'h0;
			tgl_sync_reg  <= 3'h0;
			edg_sync_reg  <= 3'h0;
			ld_sync_reg   <= 2'h0;
		end else begin
			req_sync_reg  <= {req_sync_reg[0], i_reconfig_req_b};
			st_sync_reg   <= {st_sync_reg[0], i_status_b_in};
			uclk_sync_reg <= {uclk_sync_reg[1:0], i_user_init_clock};
			tgl_sync_reg  <= {tgl_sync_reg[1:0], link_tgl};
			edg_sync_reg  <= {edg_sync_reg[1:0], link_fall};
			ld_sync_reg   <= {ld_sync_reg[0], i_load_done_in};
		end
	end

	assign req_b     = req_sync_reg[1];
	assign status_hi = st_sync_reg[1];
	assign word_evt  = tgl_sync_reg[2] ^ tgl_sync_reg[1];
	assign uclk_rise = uclk_sync_reg[1] & ~uclk_sync_reg[2];
	assign fall_evt  = edg_sync_reg[2] ^ edg_sync_reg[1];
	assign ld_high   = ld_sync_reg[1];

	// Last cycle of a timed phase that lasts n cycles
	function automatic logic span_end(input logic [31:0] c,
		input int unsigned n);
		return c >= n - 32'd1;
	endfunction : span_end

	// Falling link edges counted while the load-complete line reads high;
	// edges before that belong to the last word's ratio period
	always_comb begin
		falls_next = falls_reg;
		if (state_reg != ST_EDGES) begin
			falls_next = 2'h0;
		end else if (ld_high && fall_evt && falls_reg != END_FALLS) begin
			falls_next = falls_reg + 2'h1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			falls_reg <= 2'h0;
		end else begin
			falls_reg <= falls_next;
		end
	end

	// Sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		words_next = words_reg;
		ucnt_next  = ucnt_reg;
		st_oe_next = st_oe_reg;
		ld_oe_next = ld_oe_reg;
		id_oe_next = id_oe_reg;
		arm_next   = 1'b0;
		user_next  = 1'b0;
		mode_next  = mode_reg;
		word_next  = '{valid: 1'b0, data: word_reg.data};
		case (state_reg)
			ST_POR: begin
				st_oe_next = 1'b1;
				ld_oe_next = 1'b1;
				id_oe_next = i_init_done_opt;
				if (span_end(cnt_reg, POR_CYCLES)) begin
					cnt_next   = 32'h0;
					st_oe_next = 1'b0;
					words_next = 32'h0;
					mode_next  = i_mode;
					state_next = ST_LOAD;
				end else begin
					cnt_next = cnt_reg + 32'h1;
				end
			end
			ST_RESET: begin
				st_oe_next = 1'b1;
				ld_oe_next = 1'b1;
				id_oe_next = i_init_done_opt;
				cnt_next   = 32'h0;
				if (req_b) begin
					state_next = ST_STATUS;
				end
			end
			ST_STATUS: begin
				// Low for the least pulse, then follow the line if held
				if (span_end(cnt_reg, STATUS_CYCLES)) begin
					st_oe_next = 1'b0;
					if (status_hi && !st_oe_reg) begin
						words_next = 32'h0;
						mode_next  = i_mode;
						state_next = ST_LOAD;
					end
				end else begin
					cnt_next = cnt_reg + 32'h1;
				end
			end
			ST_LOAD: begin
				arm_next = 1'b1;
				if (word_evt) begin
					word_next  = '{valid: 1'b1, data: link_word};
					words_next = words_reg + 32'h1;
				end
				if (words_reg >= i_image_words && i_image_words != 0) begin
					arm_next   = 1'b0;
					ld_oe_next = 1'b0;
					state_next = ST_EDGES;
				end
			end
			ST_EDGES: begin
				// Waits for the host's closing falling edges
				if (falls_reg == END_FALLS) begin
					cnt_next   = 32'h0;
					ucnt_next  = 32'h0;
					state_next = ST_INIT;
				end
			end
			ST_INIT: begin
				cnt_next = cnt_reg + 32'h1;
				if (i_user_clock_opt) begin
					// User clock counted only after its enable delay
					if (cnt_reg >= 32'(CD2CU_CYC) && uclk_rise) begin
						ucnt_next = ucnt_reg + 32'h1;
					end
					if (ucnt_reg >= UCLK_PERIODS) begin
						state_next = ST_USER;
					end
				end else if (span_end(cnt_reg, INIT_CYCLES)) begin
					state_next = ST_USER;
				end
			end
			ST_USER: begin
				user_next  = 1'b1;
				id_oe_next = 1'b0;
			end
			default: begin
				state_next = ST_POR;
			end
		endcase
		// Request low aborts anything but power-on
		if (!req_b && state_reg != ST_POR) begin
			st_oe_next = 1'b1;
			ld_oe_next = 1'b1;
			arm_next   = 1'b0;
			user_next  = 1'b0;
			state_next = ST_RESET;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_POR;
			cnt_reg   <= 32'h0;
			words_reg <= 32'h0;
			ucnt_reg  <= 32'h0;
			st_oe_reg <= 1'b1;
			ld_oe_reg <= 1'b1;
			id_oe_reg <= 1'b0;
			arm_reg   <= 1'b0;
			user_reg  <= 1'b0;
			mode_reg  <= '{width: WIDTH_8, decompress: 1'b0, secure: 1'b0};
			word_reg  <= '{valid: 1'b0, data: WORD_RST};
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			words_reg <= words_next;
			ucnt_reg  <= ucnt_next;
			st_oe_reg <= st_oe_next;
			ld_oe_reg <= ld_oe_next;
			id_oe_reg <= id_oe_next;
			arm_reg   <= arm_next;
			user_reg  <= user_next;
			mode_reg  <= mode_next;
			word_reg  <= word_next;
		end
	end

	// Open-drain lines only ever pull low
	assign o_status_b_out  = 1'b0;
	assign o_load_done_out = 1'b0;
	assign o_init_done_out = 1'b0;
	assign o_status_b_oe   = st_oe_reg;
	assign o_load_done_oe  = ld_oe_reg;
	assign o_init_done_oe  = id_oe_reg;
	assign o_word          = word_reg;
	assign o_user_mode     = user_reg;

endmodule : passive_parallel_load

// File: test/ppl_chk.sv
// Concurrent checks on the ports of the parallel load port
`timescale 1ns/10ps
module ppl_chk #(
	parameter int unsigned POR_CYCLES    = 20,
	parameter int unsigned STATUS_CYCLES = 30,
	parameter int unsigned INIT_CYCLES   = 40,
	parameter int unsigned UCLK_PERIODS  = 10
) (
	input wire logic               i_clk_sys,
	input wire logic               i_rst_b,
	input wire logic               i_reconfig_req_b,
	input wire logic               o_status_b_oe,
	input wire logic               o_load_done_oe,
	input wire logic               o_init_done_oe,
	input wire logic               i_user_clock_opt,
	input wire ppl_pkg::cfg_mode_s i_mode,
	input wire ppl_pkg::cfg_word_s o_word,
	input wire logic               o_user_mode
);
	import ppl_pkg::*;
	localparam int CF2ST0 = 30;
	int unsigned hi_reg, hi_next, dn_reg, dn_next;
	logic        por_reg, por_next;
	always_comb begin
		hi_next  = i_reconfig_req_b ? hi_reg + 1 : 0;
		dn_next  = o_load_done_oe ? 0 : dn_reg + 1;
		por_next = por_reg | !o_status_b_oe;
	end
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hi_reg  <= 0;
			dn_reg  <= 0;
			por_reg <= 1'b0;
		end else begin
			hi_reg  <= hi_next;
			dn_reg  <= dn_next;
			por_reg <= por_next;
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_req_pulls_lines: assert property ($fell(i_reconfig_req_b) && o_user_mode
		|-> ##[1:CF2ST0] (o_status_b_oe && o_load_done_oe))
		else $error("lines not pulled low after request");
	a_status_min: assert property ($fell(o_status_b_oe)
		|-> hi_reg >= (por_reg ? STATUS_CYCLES : POR_CYCLES - 2))
		else $error("status low pulse too short");
	a_status_max: assert property (o_status_b_oe && por_reg
		|-> hi_reg <= STATUS_CYCLES + 8)
		else $error("status held too long");
	a_done_low_words: assert property (o_word.valid |-> o_load_done_oe)
		else $error("load complete high during transfer");
	a_user_levels: assert property (o_user_mode
		|-> !o_status_b_oe && !o_load_done_oe && !o_init_done_oe)
		else $error("line pulled low in user mode");
	a_init_low_until: assert property ($fell(o_init_done_oe) |-> o_user_mode)
		else $error("init done released early");
	a_init_internal: assert property ($rose(o_user_mode) && !i_user_clock_opt
		|-> dn_reg >= INIT_CYCLES)
		else $error("user mode too early");
	a_init_user_clk: assert property ($rose(o_user_mode) && i_user_clock_opt
		|-> dn_reg >= UCLK_PERIODS)
		else $error("user mode too early on user clock");
	a_lane_mask: assert property (o_word.valid && i_mode.width != WIDTH_32
		|-> o_word.data[31:16] == 16'h0000
		&& (i_mode.width == WIDTH_16 || o_word.data[15:8] == 8'h00))
		else $error("unused lane not zero");
	a_idle_no_word: assert property (o_user_mode |-> !o_word.valid)
		else $error("word captured in user mode");
	c_word: cover property (o_word.valid);
	c_user: cover property ($rose(o_user_mode));
	c_reconfig: cover property ($fell(i_reconfig_req_b) && o_user_mode);
endmodule : ppl_chk
bind passive_parallel_load ppl_chk #(.POR_CYCLES(POR_CYCLES),
	.STATUS_CYCLES(STATUS_CYCLES), .INIT_CYCLES(INIT_CYCLES),
	.UCLK_PERIODS(UCLK_PERIODS)) u_ppl_chk (.i_clk_sys(i_clk_sys),
	.i_rst_b(i_rst_b), .i_reconfig_req_b(i_reconfig_req_b),
	.o_status_b_oe(o_status_b_oe), .o_load_done_oe(o_load_done_oe),
	.o_init_done_oe(o_init_done_oe), .i_user_clock_opt(i_user_clock_opt),
	.i_mode(i_mode), .o_word(o_word), .o_user_mode(o_user_mode));

// File: test/ppl_host.sv
// Behavioural configuration host driving the link clock and data
`timescale 1ns/10ps
module ppl_host (
	// Frame request and load-complete line
	input  wire logic        i_go,
	input  wire logic [3:0]  i_ratio,
	input  wire logic [31:0] i_words,
	input  wire logic [31:0] i_base,
	input  wire logic        i_load_done,
	// Link
	output logic             o_config_clock,
	output logic [31:0]      o_data
);
	int n;
	initial begin
		o_config_clock = 1'b0;
		o_data         = 32'h0000_0000;
	end
	// Clock stands low outside frames; data changes after falling edges
	// Half period 62.5 ns keeps the link clock far under its limit
	always @(posedge i_go) begin
		for (n = 0; n < i_words * i_ratio; n++) begin
			if (n % i_ratio == 0)
				o_data = i_base + n / i_ratio;
			#62.5 o_config_clock = 1'b1;
			#62.5 o_config_clock = 1'b0;
		end
		wait (i_load_done === 1'b1);
		repeat (2) begin
			#62.5 o_config_clock = 1'b1;
			#62.5 o_config_clock = 1'b0;
		end
		o_data = ~o_data;
	end
endmodule : ppl_host

// File: test/testbench.sv
// Self-checking bench of the parallel load port
`timescale 1ns/10ps
module testbench;
	import ppl_pkg::*;
	localparam int POR = 20;
	localparam int STC = 30;
	localparam int INI = 40;
	localparam int UCK = 10;
	logic        i_clk_sys, i_rst_b, i_reconfig_req_b, i_user_init_clock;
	logic        i_user_clock_opt, go, st_oe, ld_oe, in_oe, user_mode;
	logic        cclk, st_w, ld_w, init_opt;
	logic [31:0] data, words, base;
	logic [3:0]  ratio;
	cfg_mode_s   mode;
	cfg_word_s   word;
	int          n_errors, check_count, seed, cyc, k, cur_w;
	// Pull-ups on the status and load-complete open-drain lines
	assign st_w = !st_oe;
	assign ld_w = !ld_oe;
	passive_parallel_load #(.POR_CYCLES(POR), .STATUS_CYCLES(STC),
		.INIT_CYCLES(INI), .UCLK_PERIODS(UCK)) u_passive_parallel_load (
		.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_config_clock(cclk),
		.i_data(data), .i_reconfig_req_b(i_reconfig_req_b),
		.i_status_b_in(st_w), .o_status_b_out(), .o_status_b_oe(st_oe),
		.i_load_done_in(ld_w), .o_load_done_out(), .o_load_done_oe(ld_oe),
		.o_init_done_out(), .o_init_done_oe(in_oe),
		.i_user_init_clock(i_user_init_clock),
		.i_user_clock_opt(i_user_clock_opt), .i_init_done_opt(init_opt),
		.i_mode(mode), .i_image_words(words), .o_word(word),
		.o_user_mode(user_mode));
	ppl_host u_ppl_host (.i_go(go), .i_ratio(ratio), .i_words(words),
		.i_base(base), .i_load_done(ld_w), .o_config_clock(cclk),
		.o_data(data));
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_user_init_clock = 1'b0;
		forever #53 i_user_init_clock = ~i_user_init_clock;
	end
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_v
	task automatic chk_min(input int got, input int lim);
		check_count++;
		if (got < lim) begin
			n_errors++;
			$display("CHECK FAILED %0t count %0d below %0d", $time, got, lim);
		end
	endtask : chk_min
	function automatic logic [3:0] exp_ratio(input int w, d, s);
		return w == 0 ? (d ? 4'h2 : 4'h1)
			: w == 1 ? (d ? 4'h4 : s ? 4'h2 : 4'h1)
			: (d ? 4'h8 : s ? 4'h4 : 4'h1);
	endfunction : exp_ratio
	function automatic logic [31:0] exp_mask(input int w);
		return w == 0 ? 32'h0000_00ff : w == 1 ? 32'h0000_ffff : 32'hffff_ffff;
	endfunction : exp_mask
	task automatic setup(input int w, d, s);
		mode  = '{width_e'(w), d[0], s[0]};
		ratio = exp_ratio(w, d, s);
		words = 32'h1 + ($random(seed) & 32'h3);
		base  = $random(seed);
		cur_w = w;
		init_opt = ($random(seed) & 1) != 0;
	endtask : setup
	task automatic reconfig();
		int t;
		@(negedge i_clk_sys);
		i_reconfig_req_b = 1'b0;
		repeat (100) @(negedge i_clk_sys);
		chk_v({st_w, ld_w}, 2'b00);
		i_reconfig_req_b = 1'b1;
		t = 0;
		while (st_w !== 1'b1 && t < 1000) begin
			@(negedge i_clk_sys);
			t++;
		end
		chk_min(t, STC);
		chk_min(STC + 8, t);
	endtask : reconfig
	task automatic load();
		int n, t;
		t = 0;
		while (st_w !== 1'b1 && t < 4000) begin
			@(negedge i_clk_sys);
			t++;
		end
		repeat (100) @(negedge i_clk_sys);
		go = 1'b1;
		n = 0;
		t = 0;
		while (ld_w !== 1'b1 && t < 2000) begin
			@(negedge i_clk_sys);
			go = 1'b0;
			t++;
			if (word.valid === 1'b1) begin
				chk_v(word.data, (base + n) & exp_mask(cur_w));
				n++;
			end
		end
		chk_v(n, words);
		chk_v(in_oe, init_opt);
		t = 0;
		while (user_mode !== 1'b1 && t < 3000) begin
			@(negedge i_clk_sys);
			t++;
		end
		chk_v(user_mode, 1'b1);
		chk_min(t, i_user_clock_opt ? UCK * 5 : INI);
		chk_v({st_w, ld_w, in_oe}, 3'b110);
	endtask : load
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		seed             = 61;
		n_errors         = 0;
		check_count      = 0;
		cyc              = 0;
		i_rst_b          = 1'b0;
		i_reconfig_req_b = 1'b1;
		i_user_clock_opt = 1'b0;
		go               = 1'b0;
		setup(2, 0, 0);
		init_opt         = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		i_rst_b = 1'b1;
		load();
		for (k = 0; k < 12; k++) begin
			setup(k / 4, k / 2 % 2, k % 2);
			reconfig();
			load();
		end
		i_user_clock_opt = 1'b1;
		setup(1, 1, 1);
		init_opt = 1'b1;
		reconfig();
		load();
		report_and_stop();
	end
endmodule : testbench
